// *** common/pps_params.svh ***
// Register map, field positions, reset values and sizes of the PWM period, duty and shutdown block
`ifndef PPS_PARAMS_SVH
`define PPS_PARAMS_SVH

// Byte offsets; each register takes one aligned 32-bit word
`define PPS_OFF_PERIOD 8'h00
`define PPS_OFF_DUTY 8'h20
`define PPS_OFF_COUNTER 8'h40
`define PPS_OFF_ENABLE 8'h60
`define PPS_OFF_START_LEVEL 8'h64
`define PPS_OFF_CENTRE_ALIGN 8'h68
`define PPS_OFF_SHUTDOWN 8'h6C
`define PPS_OFF_IRQ_STATUS 8'h70
`define PPS_OFF_IRQ_MASK 8'h74

// Shutdown control field positions
`define PPS_SDN_FLAG 7
`define PPS_SDN_IRQ_EN 6
`define PPS_SDN_RESTART 5
`define PPS_SDN_LEVEL 4
`define PPS_SDN_PIN_STATE 2
`define PPS_SDN_ACTIVE_LEVEL 1
`define PPS_SDN_ENABLE 0

// Interrupt status and mask field position
`define PPS_IRQ_SHUTDOWN 0

// Sizes and reset values
`define PPS_MAX_CH 8
`define PPS_ADDR_W 8
`define PPS_RESET_BYTE 8'h00
`define PPS_RESET_WORD 32'h0000_0000

`endif

// *** common/pps_pkg.sv ***
// Types of the PWM period, duty and shutdown block
`include "pps_params.svh"

package pps_pkg;

	typedef logic [`PPS_MAX_CH-1:0][7:0] pps_bytes_type;

	// Whole state of the block, registered in one place
	typedef struct packed {
		pps_bytes_type cnt;
		pps_bytes_type per_buf;
		pps_bytes_type per_act;
		pps_bytes_type dty_buf;
		pps_bytes_type dty_act;
		logic [`PPS_MAX_CH-1:0] dir_down;
		logic [`PPS_MAX_CH-1:0] wave;
		logic [`PPS_MAX_CH-1:0] halt;
		logic [`PPS_MAX_CH-1:0] pin;
		logic [`PPS_MAX_CH-1:0] ena;
		logic [`PPS_MAX_CH-1:0] start_level;
		logic [`PPS_MAX_CH-1:0] centre;
		logic sdn_en;
		logic irq_en;
		logic force_level;
		logic active_level;
		logic flag;
		logic sync1;
		logic sync2;
		logic prev;
		logic [31:0] rdata;
	} pps_state_type;

endpackage : pps_pkg

// *** hw/pps_pwm.sv ***
// PWM channel period and duty comparison with emergency shutdown, APB register slave
//
// Overview of operation
// - Period is tick period times value, doubled centred
// - Zero period holds output at start level
// - High fraction follows start level and duty ratio
// - Zero duty holds output opposite start level
// - Counter equal to duty toggles output
// - Shutdown disabled ignores restart bit five; bits six, four and one are still stored
// - Pin change sets flag; write one clears
// - Flag and enable raise interrupt request
// - Restart resumes at counter zero, reads zero
// - Removed shutdown resumes outputs at counter zero
// - Active shutdown forces all outputs to level
// - Bit two reads channel seven pin state
// - Bit one selects shutdown input active level
// - Enable bit makes pin input, arms shutdown
// - Left counts to period minus one; centred up-down
// - Start level bit sets first output state
// - Period and duty buffered until period end
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "pps_params.svh"

module pps_pwm
	import pps_pkg::*;
#(
	parameter int NUM_CH = `PPS_MAX_CH
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`PPS_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_CH-1:0] chan_tick,
	output logic [NUM_CH-1:0] pwm_out,
	input wire logic ch7_pin_in,
	output logic ch7_pin_out,
	output logic ch7_pin_oe_n,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Elaboration checks

	generate
		if (NUM_CH < 1 || NUM_CH > `PPS_MAX_CH)
		begin : g_bad_ch
			$error("pps_pwm: NUM_CH must lie between 1 and 8");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Address decoding

	// True when the address falls in the eight-word group at base
	function automatic logic in_group(input logic [`PPS_ADDR_W-1:0] addr, input logic [`PPS_ADDR_W-1:0] base);
		in_group = (addr[7:5] == base[7:5]);
	endfunction : in_group

	// Channel number of an address inside a group
	function automatic int unsigned chan_of(input logic [`PPS_ADDR_W-1:0] addr);
		chan_of = int'(addr[4:2]);
	endfunction : chan_of

	// True when the address names a register of this block
	function automatic logic is_mapped(input logic [`PPS_ADDR_W-1:0] addr);
		logic grp;
		grp = in_group(addr, `PPS_OFF_PERIOD) || in_group(addr, `PPS_OFF_DUTY) || in_group(addr, `PPS_OFF_COUNTER);
		is_mapped = (grp && (chan_of(addr) < NUM_CH)) || addr == `PPS_OFF_ENABLE
			|| addr == `PPS_OFF_START_LEVEL || addr == `PPS_OFF_CENTRE_ALIGN || addr == `PPS_OFF_SHUTDOWN
			|| addr == `PPS_OFF_IRQ_STATUS || addr == `PPS_OFF_IRQ_MASK;
	endfunction : is_mapped

	////////////////////////////////////////////////////////////////////////////////
	// State

	pps_state_type state_reg;
	pps_state_type state_next;

	logic wr_acc;
	logic rd_setup;
	logic shutdown_active;
	logic pin_change;
	logic restart_wr;
	logic [7:0] sdn_view;
	logic [NUM_CH-1:0] cnt_wr;

	// Access phase accepts at once; a wait state buys nothing here
	assign pready = 1'b1;
	assign pslverr = psel && penable && !is_mapped(paddr);
	assign wr_acc = psel && penable && pwrite && is_mapped(paddr);
	assign rd_setup = psel && !penable && !pwrite;
	assign prdata = state_reg.rdata;

	// Only the second synchroniser stage is looked at
	assign pin_change = state_reg.sdn_en && (state_reg.sync2 != state_reg.prev);
	assign shutdown_active = state_reg.sdn_en && (state_reg.sync2 == state_reg.active_level);
	assign restart_wr = wr_acc && paddr == `PPS_OFF_SHUTDOWN && pwdata[`PPS_SDN_RESTART] && state_reg.sdn_en;

	// Read view of shutdown control; restart always reads zero
	always_comb
	begin
		sdn_view = `PPS_RESET_BYTE;
		sdn_view[`PPS_SDN_FLAG] = state_reg.flag;
		sdn_view[`PPS_SDN_IRQ_EN] = state_reg.irq_en;
		sdn_view[`PPS_SDN_LEVEL] = state_reg.force_level;
		sdn_view[`PPS_SDN_PIN_STATE] = state_reg.sync2;
		sdn_view[`PPS_SDN_ACTIVE_LEVEL] = state_reg.active_level;
		sdn_view[`PPS_SDN_ENABLE] = state_reg.sdn_en;
	end

	// Counter write strobes, one per channel
	always_comb
	begin
		cnt_wr = '0;
		for (int c = 0; c < NUM_CH; c++)
		begin
			cnt_wr[c] = wr_acc && in_group(paddr, `PPS_OFF_COUNTER) && chan_of(paddr) == c;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		state_next = state_reg;

		// Shutdown input: two flip-flops, then a copy for change detection
		state_next.sync1 = ch7_pin_in;
		state_next.sync2 = state_reg.sync1;
		state_next.prev = state_reg.sync2;

		// Read data captured in the setup phase, presented in the access phase
		if (rd_setup)
		begin
			state_next.rdata = `PPS_RESET_WORD;
			if (in_group(paddr, `PPS_OFF_PERIOD) && chan_of(paddr) < NUM_CH)
				state_next.rdata[7:0] = state_reg.per_buf[chan_of(paddr)];
			else if (in_group(paddr, `PPS_OFF_DUTY) && chan_of(paddr) < NUM_CH)
				state_next.rdata[7:0] = state_reg.dty_buf[chan_of(paddr)];
			else if (in_group(paddr, `PPS_OFF_COUNTER) && chan_of(paddr) < NUM_CH)
				state_next.rdata[7:0] = state_reg.cnt[chan_of(paddr)];
			else if (paddr == `PPS_OFF_ENABLE)
				state_next.rdata[`PPS_MAX_CH-1:0] = state_reg.ena;
			else if (paddr == `PPS_OFF_START_LEVEL)
				state_next.rdata[`PPS_MAX_CH-1:0] = state_reg.start_level;
			else if (paddr == `PPS_OFF_CENTRE_ALIGN)
				state_next.rdata[`PPS_MAX_CH-1:0] = state_reg.centre;
			else if (paddr == `PPS_OFF_SHUTDOWN)
				state_next.rdata[7:0] = sdn_view;
			else if (paddr == `PPS_OFF_IRQ_STATUS)
				state_next.rdata[`PPS_IRQ_SHUTDOWN] = state_reg.flag;
			else if (paddr == `PPS_OFF_IRQ_MASK)
				state_next.rdata[`PPS_IRQ_SHUTDOWN] = state_reg.irq_en;
		end

		// Plain control writes
		if (wr_acc)
		begin
			if (paddr == `PPS_OFF_ENABLE)
				state_next.ena = pwdata[`PPS_MAX_CH-1:0];
			if (paddr == `PPS_OFF_START_LEVEL)
				state_next.start_level = pwdata[`PPS_MAX_CH-1:0];
			if (paddr == `PPS_OFF_CENTRE_ALIGN)
				state_next.centre = pwdata[`PPS_MAX_CH-1:0];
			if (paddr == `PPS_OFF_SHUTDOWN)
			begin
				state_next.irq_en = pwdata[`PPS_SDN_IRQ_EN];
				state_next.force_level = pwdata[`PPS_SDN_LEVEL];
				state_next.active_level = pwdata[`PPS_SDN_ACTIVE_LEVEL];
				state_next.sdn_en = pwdata[`PPS_SDN_ENABLE];
			end
			if (paddr == `PPS_OFF_IRQ_MASK)
				state_next.irq_en = pwdata[`PPS_IRQ_SHUTDOWN];
		end

		// Change flag: write one clears, a change in the same cycle wins
		if (wr_acc && paddr == `PPS_OFF_SHUTDOWN && pwdata[`PPS_SDN_FLAG])
			state_next.flag = 1'b0;
		if (wr_acc && paddr == `PPS_OFF_IRQ_STATUS && pwdata[`PPS_IRQ_SHUTDOWN])
			state_next.flag = 1'b0;
		if (pin_change)
			state_next.flag = 1'b1;

		// Channel timers
		for (int c = 0; c < NUM_CH; c++)
		begin
			logic [7:0] per_now;
			logic [7:0] dty_now;
			logic [7:0] cnt_new;
			logic wrap;
			logic ticked;
			per_now = state_reg.per_act[c];
			dty_now = state_reg.dty_act[c];
			cnt_new = state_reg.cnt[c];
			wrap = 1'b0;
			ticked = 1'b0;

			// Buffered writes; a stopped channel takes them at once
			if (wr_acc && in_group(paddr, `PPS_OFF_PERIOD) && chan_of(paddr) == c)
				state_next.per_buf[c] = pwdata[7:0];
			if (wr_acc && in_group(paddr, `PPS_OFF_DUTY) && chan_of(paddr) == c)
				state_next.dty_buf[c] = pwdata[7:0];

			if (cnt_wr[c])
			begin
				// Counter write restarts the waveform with fresh values
				cnt_new = 8'h00;
				wrap = 1'b1;
				state_next.dir_down[c] = 1'b0;
			end
			else if (!state_reg.ena[c])
			begin
				// Stopped counter holds; a zero period resets it on the next tick
				if (chan_tick[c] && per_now == 8'h00)
					cnt_new = 8'h00;
			end
			else if (chan_tick[c])
			begin
				ticked = 1'b1;
				if (!state_reg.centre[c])
				begin
					// Left aligned: 0 .. period-1, period end reloads
					if (state_reg.cnt[c] >= per_now - 8'h01 || per_now == 8'h00)
					begin
						cnt_new = 8'h00;
						wrap = 1'b1;
					end
					else
						cnt_new = state_reg.cnt[c] + 8'h01;
				end
				else if (!state_reg.dir_down[c])
				begin
					// Centred rising half: turn at period, twice the length
					cnt_new = (state_reg.cnt[c] >= per_now) ? state_reg.cnt[c] - 8'h01 : state_reg.cnt[c] + 8'h01;
					state_next.dir_down[c] = (state_reg.cnt[c] + 8'h01 >= per_now);
					if (per_now == 8'h00)
					begin
						cnt_new = 8'h00;
						state_next.dir_down[c] = 1'b0;
						wrap = 1'b1;
					end
				end
				else
				begin
					// Centred falling half: period ends back at zero
					cnt_new = state_reg.cnt[c] - 8'h01;
					if (state_reg.cnt[c] <= 8'h01)
					begin
						cnt_new = 8'h00;
						state_next.dir_down[c] = 1'b0;
						wrap = 1'b1;
					end
				end
			end
			state_next.cnt[c] = cnt_new;

			// Active values follow buffers at period end, counter write, or while stopped
			if (wrap || !state_reg.ena[c])
			begin
				state_next.per_act[c] = state_next.per_buf[c];
				state_next.dty_act[c] = state_next.dty_buf[c];
			end

			// Output flip-flop: start level at each period, toggle on duty match
			if (wrap)
				state_next.wave[c] = state_reg.start_level[c];
			else if (ticked && cnt_new == dty_now)
				state_next.wave[c] = !state_reg.wave[c];

			// Hold outputs from shutdown or restart until the counter reaches zero
			if (shutdown_active || (restart_wr && state_reg.ena[c]))
				state_next.halt[c] = 1'b1;
			else if (state_reg.halt[c] && (cnt_new == 8'h00) && (wrap || !state_reg.ena[c]))
				state_next.halt[c] = 1'b0;

			// Pin value: shutdown forcing first, then boundary cases
			if (shutdown_active || state_reg.halt[c])
				state_next.pin[c] = state_reg.force_level;
			else if (!state_reg.ena[c])
				state_next.pin[c] = state_reg.start_level[c];
			else if (state_reg.per_act[c] == 8'h00)
				state_next.pin[c] = state_reg.start_level[c];
			else if (state_reg.dty_act[c] == 8'h00)
				state_next.pin[c] = !state_reg.start_level[c];
			else
				state_next.pin[c] = state_reg.wave[c];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign pwm_out = state_reg.pin[NUM_CH-1:0];
	assign ch7_pin_out = state_reg.pin[NUM_CH-1];
	// Pin turns to input while shutdown is armed
	assign ch7_pin_oe_n = state_reg.sdn_en;
	// Level interrupt, gated off entirely when shutdown is disarmed
	assign irq = state_reg.flag && state_reg.irq_en && state_reg.sdn_en;

endmodule : pps_pwm
`default_nettype wire

// *** tb/pps_load_model.sv ***
// Fault source and load on the shared channel seven pin
`timescale 1ns/10ps
`default_nettype none
module pps_load_model (
	input wire logic fault_level,
	input wire logic ch7_pin_out,
	input wire logic ch7_pin_oe_n,
	output logic ch7_pin_in
);
	// The fault source wins the wire only once the device lets go of it
	assign ch7_pin_in = ch7_pin_oe_n ? fault_level : ch7_pin_out;
endmodule : pps_load_model
`default_nettype wire

// *** tb/pps_pwm_checker.sv ***
// Port assertions of the PWM period, duty and shutdown block
`timescale 1ns/10ps
`default_nettype none
`include "pps_params.svh"
module pps_pwm_checker #(
	parameter int NUM_CH = 8
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`PPS_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [NUM_CH-1:0] pwm_out,
	input wire logic ch7_pin_in,
	input wire logic ch7_pin_out,
	input wire logic ch7_pin_oe_n,
	input wire logic irq
);
	logic [4:0] hist;
	logic wr_q;
	// Pin and write history, so an interrupt edge can be traced to its cause
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			{hist, wr_q} <= '0;
		else
			{hist, wr_q} <= {hist[3:0], ch7_pin_in, psel & penable & pwrite};
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_acc; psel && penable; endsequence
	sequence s_sdn_wr; s_acc ##0 pwrite && paddr == `PPS_OFF_SHUTDOWN; endsequence
	a_ready_high: assert property (pready) else $error("pready low");
	a_slverr_access: assert property (pslverr |-> psel && penable && (pwrite || prdata == 32'h0000_0000))
		else $error("bad error response");
	a_oe_follows_enable: assert property (s_sdn_wr |=> ch7_pin_oe_n == $past(pwdata[0]))
		else $error("pin direction wrong");
	a_pin_mirror: assert property (ch7_pin_out == pwm_out[NUM_CH-1]) else $error("pin value differs");
	a_restart_zero: assert property (s_acc ##0 !pwrite && paddr == `PPS_OFF_SHUTDOWN |-> !prdata[5])
		else $error("restart reads one");
	a_upper_zero: assert property (s_acc ##0 !pwrite |-> prdata[31:8] == 24'h00_0000) else $error("upper bits set");
	a_irq_fall_write: assert property ($fell(irq) |-> wr_q) else $error("irq fell unasked");
	a_irq_rise_cause: assert property ($rose(irq) |-> wr_q || hist[4:1] != {4{hist[1]}})
		else $error("irq rose unasked");
endmodule : pps_pwm_checker
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench of the PWM period, duty and shutdown block
`timescale 1ns/10ps
`default_nettype none
`include "pps_params.svh"
module tb_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fault = 0, er;
	logic [7:0] paddr = '0, tick = '0, pwm_out;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, pin_in, pin_out, oe_n, irq;
	logic [7:0] per[4] = '{8'h04, 8'h04, 8'h00, 8'h04};
	logic [7:0] dty[4] = '{8'h01, 8'h01, 8'h02, 8'h00};
	int ex[4] = '{16, 48, 64, 64};
	int err_count = 0, checked = 0, hi[4];
	pps_pwm i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .chan_tick(tick), .pwm_out(pwm_out),
		.ch7_pin_in(pin_in), .ch7_pin_out(pin_out), .ch7_pin_oe_n(oe_n), .irq(irq));
	pps_load_model i_load (.fault_level(fault), .ch7_pin_out(pin_out), .ch7_pin_oe_n(oe_n), .ch7_pin_in(pin_in));
	initial forever #5 pclk = ~pclk;
	// Channel ticks every second cycle, so one count lasts two clocks
	always @(posedge pclk) tick <= presetn ? ~tick : 8'h00;
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
		@(posedge pclk);
		penable <= 1'h1;
		do
			@(posedge pclk);
		while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'h0;
		@(posedge pclk);
	endtask : xfer
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
		xfer(1'h0, a, 32'h0000_0000);
		chk(n, e, rd);
	endtask : rdc
	task automatic summarize();
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		rdc("shutdown reset", `PPS_OFF_SHUTDOWN, 32'h0000_0000);
		xfer(1'h0, 8'h80, 32'h0000_0000);
		chk("unmapped", 32'h0000_0001, {rd[30:0], er});
		// Left 1/4, centred 3/4, zero period, zero duty
		for (int c = 0; c < 4; c++)
		begin
			xfer(1'h1, `PPS_OFF_PERIOD + 8'(4 * c), {24'h0, per[c]});
			xfer(1'h1, `PPS_OFF_DUTY + 8'(4 * c), {24'h0, dty[c]});
			xfer(1'h1, `PPS_OFF_COUNTER + 8'(4 * c), 32'h0000_0000);
		end
		rdc("period", `PPS_OFF_PERIOD, 32'h0000_0004);
		xfer(1'h1, `PPS_OFF_START_LEVEL, 32'h0000_0005);
		xfer(1'h1, `PPS_OFF_CENTRE_ALIGN, 32'h0000_0002);
		xfer(1'h1, `PPS_OFF_ENABLE, 32'h0000_000F);
		repeat (40) @(posedge pclk);
		// Whole periods fit the window, so the start phase does not matter
		hi = '{default: 0};
		repeat (64)
		begin
			@(posedge pclk);
			foreach (hi[c])
				hi[c] += int'(pwm_out[c]);
		end
		foreach (hi[c])
			chk("high time", ex[c], 32'(hi[c]));
		xfer(1'h1, `PPS_OFF_SHUTDOWN, 32'h0000_0053);
		chk("pin released", 32'h0000_0001, {31'h0, oe_n});
		fault <= 1'h1;
		repeat (8) @(posedge pclk);
		chk("forced", 32'h0000_00FF, {24'h0, pwm_out});
		chk("irq set", 32'h0000_0001, {31'h0, irq});
		rdc("shutdown flag", `PPS_OFF_SHUTDOWN, 32'h0000_00D7);
		xfer(1'h1, `PPS_OFF_SHUTDOWN, 32'h0000_00D3);
		chk("irq cleared", 32'h0000_0000, {31'h0, irq});
		fault <= 1'h0;
		repeat (8) @(posedge pclk);
		chk("irq again", 32'h0000_0001, {31'h0, irq});
		xfer(1'h1, `PPS_OFF_IRQ_MASK, 32'h0000_0000);
		chk("irq masked", 32'h0000_0000, {31'h0, irq});
		rdc("status", `PPS_OFF_IRQ_STATUS, 32'h0000_0001);
		xfer(1'h1, `PPS_OFF_IRQ_STATUS, 32'h0000_0001);
		rdc("status clear", `PPS_OFF_IRQ_STATUS, 32'h0000_0000);
		repeat (40) @(posedge pclk);
		// Zero period holds start level high, zero duty with low start level holds high
		chk("resumed", 32'h0000_0003, {30'h0, pwm_out[3:2]});
		// Pending flag with interrupt enable set must stay silent once shutdown is disarmed
		fault <= 1'h1;
		repeat (8) @(posedge pclk);
		chk("masked flag", 32'h0000_0000, {31'h0, irq});
		rdc("status set", `PPS_OFF_IRQ_STATUS, 32'h0000_0001);
		xfer(1'h1, `PPS_OFF_SHUTDOWN, 32'h0000_0052);
		chk("pin driven", 32'h0000_0000, {31'h0, oe_n});
		chk("disarmed irq", 32'h0000_0000, {31'h0, irq});
		repeat (8) @(posedge pclk);
		chk("ignored", 32'h0000_0001, {30'h0, irq, pwm_out[2]});
		xfer(1'h1, `PPS_OFF_SHUTDOWN, 32'h0000_0020);
		rdc("restart", `PPS_OFF_SHUTDOWN, 32'h0000_0080);
		summarize();
	end
	// Watchdog far beyond the few hundred cycles the sequence needs
	initial
	begin
		#100us;
		err_count++;
		summarize();
	end
endmodule : tb_top
bind pps_pwm pps_pwm_checker #(.NUM_CH(NUM_CH)) i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .pwm_out(pwm_out), .ch7_pin_in(ch7_pin_in), .ch7_pin_out(ch7_pin_out),
	.ch7_pin_oe_n(ch7_pin_oe_n), .irq(irq));
`default_nettype wire
